// >>> src/spe_pkg.sv
// spe_pkg: shared constants and types of the SPI port controller
package spe_pkg;
   localparam int CS_N = 4;
   localparam int CS_W = 2;
   localparam int DIV_W = 8;
   localparam int BITS_W = 4;
   localparam int DW = 16;
   localparam int TXW = 32;
   localparam int FINAL_BIT = 24;
   localparam int CS_LO = 16;
   localparam int BITS_BASE = 8;
   localparam int SLV_BITS = 8;
   localparam int SLV_CW = 4;
   localparam int CNT_W = 6;
   localparam logic [BITS_W-1:0] BITS_MAX_CODE = 4'h8;
   localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
   localparam logic [CNT_W-1:0] EXTRA_EDGES = 6'h02;
   localparam logic [4:0] BYTE_BITS = 5'h08;

   // one-hot master sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_LEAD = 4'h2,
      ST_SHIFT = 4'h4,
      ST_DONE = 4'h8
   } spe_state_t;
endpackage : spe_pkg

// >>> src/spe_sync.sv
// spe_sync: two-flop synchroniser for levels entering the system clock
`timescale 1ns/1ps
module spe_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // level in and out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   // first stage feeds only the second stage
   always_comb begin
      next_meta = d_i;
      next_q = meta;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= next_meta;
         q_o <= next_q;
      end
   end
endmodule : spe_sync

// >>> src/spe_fifo2.sv
// spe_fifo2: small flop buffer with valid/ready on both sides
`timescale 1ns/1ps
module spe_fifo2 #(
   parameter int W = 16,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("spe_fifo2: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr, next_wr, rd, next_rd;
   logic [AW:0] cnt, next_cnt;
   logic push, pop;

   assign in_ready_o = (cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt != '0);
   assign out_data_o = mem[rd];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // pointer and level update
   always_comb begin
      next_wr = push ? wr + 1'b1 : wr;
      next_rd = pop ? rd + 1'b1 : rd;
      next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wr <= '0;
         rd <= '0;
         cnt <= '0;
      end else begin
         wr <= next_wr;
         rd <= next_rd;
         cnt <= next_cnt;
      end
   end

   // storage holds no reset, only written words are ever read
   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wr] <= in_data_i;
      end
   end
endmodule : spe_fifo2

// >>> src/spe_core.sv
// spe_core: SPI master/slave controller with its known clocking quirks
`timescale 1ns/1ps
module spe_core import spe_pkg::*; #(
   parameter int NCS = CS_N,
   parameter int DEPTH = 2
) (
   // system
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // commands, one-cycle pulses
   input wire logic enable_cmd_i,
   input wire logic disable_cmd_i,
   input wire logic soft_reset_cmd_i,
   // mode
   input wire logic master_select_bit_i,
   input wire logic fixed_mode_i,
   input wire logic dma_mode_i,
   input wire logic [CS_W-1:0] fixed_cs_i,
   // per-select configuration
   input wire logic [NCS*DIV_W-1:0] baud_divisor_i,
   input wire logic [NCS*BITS_W-1:0] bits_code_i,
   input wire logic [NCS-1:0] cpol_i,
   input wire logic [NCS-1:0] cpha_i,
   input wire logic [NCS-1:0] hold_select_after_transfer_i,
   input wire logic config_wr_i,
   // transmit words
   input wire logic tx_valid_i,
   input wire logic [TXW-1:0] tx_data_i,
   output logic tx_ready_o,
   // receive words
   output logic rx_valid_o,
   output logic [DW-1:0] rx_data_o,
   input wire logic rx_ready_i,
   // status
   output logic enabled_o,
   output logic transmit_empty_flag_o,
   output logic dma_halfword_o,
   // master pins
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_o,
   output logic mosi_o,
   output logic mosi_oe_o,
   output logic [NCS-1:0] cs_n_o,
   input wire logic miso_i,
   // slave link
   input wire logic slv_clk_i,
   input wire logic slv_cs_n_i,
   input wire logic slv_mosi_i,
   output logic slv_miso_o,
   output logic slv_miso_oe_o
);
   if (NCS < 1 || NCS > (1 << CS_W)) begin : g_bad_ncs
      $error("spe_core: NCS out of range");
   end

   // zero divisor behaves as one
   function automatic logic [DIV_W-1:0] pick_div(input logic [NCS*DIV_W-1:0] v,
                                                 input logic [CS_W-1:0] i);
      logic [DIV_W-1:0] d;
      d = v[i*DIV_W +: DIV_W];
      pick_div = (d == '0) ? DIV_ONE : d;
   endfunction : pick_div

   // bit count of a select, 8 to 16
   function automatic logic [4:0] pick_bits(input logic [NCS*BITS_W-1:0] v,
                                            input logic [CS_W-1:0] i);
      logic [BITS_W-1:0] c;
      c = v[i*BITS_W +: BITS_W];
      if (c > BITS_MAX_CODE) begin
         c = BITS_MAX_CODE;
      end
      pick_bits = 5'(BITS_BASE) + {1'b0, c};
   endfunction : pick_bits

   ////////////////////////////////////////////////////////////////////////
   spe_state_t state, next_state;
   logic [DIV_W-1:0] div_cnt, next_div_cnt, cur_div, next_cur_div;
   logic [CNT_W-1:0] ecnt, next_ecnt, etotal, next_etotal;
   logic [DW-1:0] txsh, next_txsh, rxsh, next_rxsh;
   logic [4:0] cur_bits, next_cur_bits;
   logic [CS_W-1:0] cur_cs, next_cur_cs;
   logic sclk, next_sclk, cur_cpol, next_cur_cpol, cur_cpha, next_cur_cpha;
   logic cur_hold, next_cur_hold, cur_final, next_cur_final;
   logic enabled, next_enabled, tx_full, next_tx_full;
   logic dummy_run, next_dummy_run, reset_once, next_reset_once;
   logic misconfig, next_misconfig, r3_stuck, next_r3_stuck, held, next_held;
   logic [TXW-1:0] tx_word, next_tx_word;
   logic slv_pend, next_slv_pend, slv_seen, next_slv_seen;
   logic [SLV_BITS-1:0] slv_cap, next_slv_cap;
   logic [SLV_CW-1:0] slv_cnt, next_slv_cnt;
   logic [SLV_BITS-1:0] slv_sh, next_slv_sh;
   logic miso_s, slv_done_s;
   logic [CS_W-1:0] sel_cs;
   logic [DIV_W-1:0] sel_div;
   logic [4:0] sel_bits;
   logic sel_cpol, sel_cpha, sel_hold, sel_extra;
   logic go, r3_hit, tick, last_edge, lead_edge, cap_edge, cs_on;
   logic rx_push, rx_in_ready;
   logic [DW-1:0] rx_in_data;
   logic [TXW-1:0] tx_src;

   // selection of the next transfer's configuration
   assign sel_cs = fixed_mode_i ? fixed_cs_i : tx_word[CS_LO +: CS_W];
   assign sel_div = pick_div(baud_divisor_i, sel_cs);
   assign sel_bits = pick_bits(bits_code_i, sel_cs);
   assign sel_cpol = cpol_i[sel_cs];
   assign sel_cpha = cpha_i[sel_cs];
   assign sel_hold = hold_select_after_transfer_i[sel_cs];
   assign sel_extra = (sel_div != DIV_ONE && sel_div[0] && sel_cpol && !sel_cpha)
                   || (sel_div == DIV_ONE && sel_bits[0]);
   assign tx_src = dummy_run ? '0 : tx_word;
   assign go = (state == ST_IDLE) && (enabled || dummy_run) && master_select_bit_i
            && (tx_full || dummy_run) && !soft_reset_cmd_i;
   // the select is still held from an idle gap at divisor one: the shifter reloads once without a pop
   assign r3_hit = held && (sel_cs == cur_cs) && sel_hold && (sel_div == DIV_ONE)
                && !r3_stuck && !dummy_run;
   assign tick = (div_cnt == cur_div - DIV_ONE);
   assign last_edge = tick && (ecnt == etotal - 6'h01);
   assign lead_edge = !ecnt[0];
   assign cap_edge = (lead_edge == !cur_cpha) && (ecnt < {cur_bits, 1'b0});

   ////////////////////////////////////////////////////////////////////////
   // master sequencer and shifters
   always_comb begin
      next_state = state;
      next_div_cnt = div_cnt;
      next_cur_div = cur_div;
      next_ecnt = ecnt;
      next_etotal = etotal;
      next_txsh = txsh;
      next_rxsh = rxsh;
      next_cur_bits = cur_bits;
      next_cur_cs = cur_cs;
      next_sclk = sclk;
      next_cur_cpol = cur_cpol;
      next_cur_cpha = cur_cpha;
      next_cur_hold = cur_hold;
      next_cur_final = cur_final;
      case (state)
         ST_IDLE: begin
            // clock written before the master bit idles at the wrong level
            next_sclk = misconfig ? !sel_cpol : sel_cpol;
            if (go) begin
               next_cur_div = sel_div;
               next_cur_bits = sel_bits;
               next_cur_cs = sel_cs;
               next_cur_cpol = sel_cpol;
               next_cur_cpha = sel_cpha;
               next_cur_hold = sel_hold;
               next_cur_final = tx_src[FINAL_BIT];
               next_etotal = ({1'b0, sel_bits} << 1) + (sel_extra ? EXTRA_EDGES : '0);
               next_txsh = tx_src[DW-1:0] << (5'(DW) - sel_bits);
               next_rxsh = '0;
               next_ecnt = '0;
               next_div_cnt = '0;
               // the lone-reset lead pulse starts at once, with every select still high
               next_sclk = reset_once ? !sel_cpol : sel_cpol;
               // after a lone soft reset the clock moves before select
               next_state = reset_once ? ST_LEAD : ST_SHIFT;
            end
         end
         ST_LEAD: begin
            next_sclk = !cur_cpol;
            next_div_cnt = tick ? '0 : div_cnt + DIV_ONE;
            if (tick) begin
               next_sclk = cur_cpol;
               next_state = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            next_div_cnt = tick ? '0 : div_cnt + DIV_ONE;
            if (tick) begin
               next_sclk = !sclk;
               next_ecnt = ecnt + 6'h01;
               if (cap_edge) begin
                  next_rxsh = {rxsh[DW-2:0], miso_s};
               end else if (ecnt != '0 && ecnt < {cur_bits, 1'b0}) begin
                  next_txsh = txsh << 1;
               end
               // extra edges past the word move the clock only
               if (last_edge) begin
                  next_state = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            // a full receive buffer holds the sequencer here
            if (rx_in_ready) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (soft_reset_cmd_i) begin
         next_state = ST_IDLE;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         div_cnt <= '0;
         cur_div <= DIV_ONE;
         ecnt <= '0;
         etotal <= '0;
         txsh <= '0;
         rxsh <= '0;
         cur_bits <= BYTE_BITS;
         cur_cs <= '0;
         sclk <= 1'b0;
         cur_cpol <= 1'b0;
         cur_cpha <= 1'b0;
         cur_hold <= 1'b0;
         cur_final <= 1'b0;
      end else begin
         state <= next_state;
         div_cnt <= next_div_cnt;
         cur_div <= next_cur_div;
         ecnt <= next_ecnt;
         etotal <= next_etotal;
         txsh <= next_txsh;
         rxsh <= next_rxsh;
         cur_bits <= next_cur_bits;
         cur_cs <= next_cur_cs;
         sclk <= next_sclk;
         cur_cpol <= next_cur_cpol;
         cur_cpha <= next_cur_cpha;
         cur_hold <= next_cur_hold;
         cur_final <= next_cur_final;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control flags and the transmit holding word
   always_comb begin
      next_enabled = enabled;
      next_tx_full = tx_full;
      next_tx_word = tx_word;
      next_dummy_run = dummy_run;
      next_reset_once = reset_once;
      next_misconfig = misconfig;
      next_r3_stuck = r3_stuck;
      next_held = held;
      if (go) begin
         next_r3_stuck = r3_hit;
         next_held = 1'b0;
         next_misconfig = 1'b0;
         if (!r3_hit && !dummy_run) begin
            next_tx_full = 1'b0;
         end
      end
      // select stays only when held and the word is not the final one
      if (state == ST_DONE && rx_in_ready) begin
         next_held = cur_hold && !cur_final;
      end
      if (tx_valid_i && tx_ready_o) begin
         next_tx_full = 1'b1;
         next_tx_word = tx_data_i;
      end
      if (config_wr_i && !master_select_bit_i) begin
         next_misconfig = 1'b1;
      end
      if (enable_cmd_i) begin
         next_enabled = 1'b1;
      end
      // the slave side never sees the disable
      if (disable_cmd_i && master_select_bit_i) begin
         next_enabled = 1'b0;
         next_held = 1'b0;
         if (state != ST_IDLE || tx_full) begin
            next_dummy_run = 1'b1;
         end
      end
      // only soft reset gets out of the dummy loop or slave mode
      if (soft_reset_cmd_i) begin
         next_enabled = 1'b0;
         next_tx_full = 1'b0;
         next_dummy_run = 1'b0;
         next_r3_stuck = 1'b0;
         next_held = 1'b0;
         next_reset_once = !reset_once;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         enabled <= 1'b0;
         tx_full <= 1'b0;
         tx_word <= '0;
         dummy_run <= 1'b0;
         reset_once <= 1'b0;
         misconfig <= 1'b0;
         r3_stuck <= 1'b0;
         held <= 1'b0;
      end else begin
         enabled <= next_enabled;
         tx_full <= next_tx_full;
         tx_word <= next_tx_word;
         dummy_run <= next_dummy_run;
         reset_once <= next_reset_once;
         misconfig <= next_misconfig;
         r3_stuck <= next_r3_stuck;
         held <= next_held;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // slave link: the frame's own select clears it, the clock may stop
   always_comb begin
      next_slv_cnt = slv_cnt;
      next_slv_sh = slv_sh;
      if (!slv_cnt[SLV_CW-1]) begin
         next_slv_cnt = slv_cnt + 4'h1;
         next_slv_sh = {slv_sh[SLV_BITS-2:0], slv_mosi_i};
      end
   end

   always_ff @(posedge slv_clk_i or posedge slv_cs_n_i) begin
      if (slv_cs_n_i) begin
         slv_cnt <= '0;
         slv_sh <= '0;
      end else begin
         slv_cnt <= next_slv_cnt;
         slv_sh <= next_slv_sh;
      end
   end

   spe_sync #(.W(2)) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i({slv_cnt[SLV_CW-1], miso_i}),
      .q_o({slv_done_s, miso_s})
   );

   // the word stays still while the done level is high, so it is safe to take
   always_comb begin
      next_slv_seen = slv_done_s;
      next_slv_pend = slv_pend;
      next_slv_cap = slv_cap;
      if (slv_pend && rx_in_ready && !master_select_bit_i) begin
         next_slv_pend = 1'b0;
      end
      if (slv_done_s && !slv_seen && enabled && !master_select_bit_i) begin
         next_slv_pend = 1'b1;
         next_slv_cap = slv_sh;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         slv_seen <= 1'b0;
         slv_pend <= 1'b0;
         slv_cap <= '0;
      end else begin
         slv_seen <= next_slv_seen;
         slv_pend <= next_slv_pend;
         slv_cap <= next_slv_cap;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive buffer
   assign rx_push = master_select_bit_i ? (state == ST_DONE) : slv_pend;
   assign rx_in_data = master_select_bit_i ? rxsh : {{(DW-SLV_BITS){1'b0}}, slv_cap};

   spe_fifo2 #(.W(DW), .DEPTH(DEPTH)) u_rxbuf (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(rx_push),
      .in_data_i(rx_in_data),
      .in_ready_o(rx_in_ready),
      .out_valid_o(rx_valid_o),
      .out_data_o(rx_data_o),
      .out_ready_i(rx_ready_i)
   );

   // outputs
   assign tx_ready_o = enabled && !tx_full && !r3_stuck;
   assign enabled_o = enabled;
   assign transmit_empty_flag_o = !tx_full && (state == ST_IDLE);
   // fixed select with DMA always reads the size from select 0
   assign dma_halfword_o = pick_bits(bits_code_i, (fixed_mode_i && dma_mode_i)
                           ? '0 : sel_cs) > BYTE_BITS;
   assign serial_clock_pin_o = sclk;
   assign serial_clock_pin_oe_o = master_select_bit_i;
   assign mosi_o = txsh[DW-1];
   assign mosi_oe_o = master_select_bit_i;
   assign cs_on = (state == ST_SHIFT) || (state == ST_DONE) || held;
   assign slv_miso_o = slv_sh[SLV_BITS-1];
   assign slv_miso_oe_o = !slv_cs_n_i && !master_select_bit_i;

   for (genvar g = 0; g < NCS; g++) begin : g_cs
      assign cs_n_o[g] = !(cs_on && (cur_cs == CS_W'(g)));
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   lead_clock_a: assert property (go && reset_once |=>
      state == ST_LEAD && (&cs_n_o) && sclk == !cur_cpol)
      else $error("clock not ahead of select after single reset");
   odd_baud_a: assert property (go && sel_div != DIV_ONE && sel_div[0]
      && sel_cpol && !sel_cpha |=> etotal == ({1'b0, cur_bits} << 1) + 6'h02)
      else $error("odd divisor pulse count wrong");
   fast_odd_a: assert property (go && sel_div == DIV_ONE |=>
      etotal == ({1'b0, cur_bits} << 1) + (cur_bits[0] ? 6'h02 : 6'h00))
      else $error("divisor one pulse count wrong");
   stuck_ready_a: assert property (go && r3_hit |=> (!tx_ready_o && tx_full)[*3])
      else $error("ready rose on held same-slave reload");
   final_release_a: assert property (state == ST_DONE && rx_in_ready && cur_final
      && !soft_reset_cmd_i |=> (&cs_n_o) && !held)
      else $error("select held after final word");
   dma_size_a: assert property (fixed_mode_i && dma_mode_i |->
      dma_halfword_o == (bits_code_i[BITS_W-1:0] != 4'h0))
      else $error("dma size not from select 0");
   slave_disable_a: assert property (disable_cmd_i && !master_select_bit_i && enabled
      && !soft_reset_cmd_i |=> enabled_o)
      else $error("disable took effect in slave mode");
   dummy_run_a: assert property (disable_cmd_i && master_select_bit_i
      && state == ST_SHIFT && !soft_reset_cmd_i |=> dummy_run && !enabled)
      else $error("disable in transfer did not start dummy run");
   config_glitch_a: assert property (config_wr_i && !master_select_bit_i
      && !soft_reset_cmd_i |=> misconfig)
      else $error("early configuration not flagged");
endmodule : spe_core

// >>> tb/spe_peer.sv
// spe_peer: serial slave on the master pins and link master for slave frames
`timescale 1ns/1ps
module spe_peer (
   // master pins
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   // link side
   output logic lclk_o,
   output logic lcs_n_o,
   output logic lmosi_o
);
   logic [15:0] cap = 16'h0000;
   initial begin
      miso_o = 1'h0;
      lclk_o = 1'h0;
      lcs_n_o = 1'h0;
      lmosi_o = 1'h0;
      // a rising select clears the link shifter before any frame
      #5 lcs_n_o = 1'h1;
   end
   // capture on the rising clock, msb first, while selected
   always @(posedge sclk_i) if (!cs_n_i) cap <= {cap[14:0], mosi_i};
   always @(negedge cs_n_i) cap <= 16'h0000;
   // a released line flips so a stale value never passes
   always @(cs_n_i or cap) miso_o = cs_n_i ? ~miso_o : cap[15];
   // link clock runs only inside a frame, 30 ns period
   task automatic frame(input logic [7:0] b);
      lcs_n_o = 1'h0;
      #40;
      for (int i = 7; i >= 0; i--) begin
         lmosi_o = b[i];
         #15 lclk_o = 1'h1;
         #15 lclk_o = 1'h0;
      end
      // select stays low until the word has crossed into the system clock
      #200 lcs_n_o = 1'h1;
      lmosi_o = ~b[0];
   endtask : frame
endmodule : spe_peer

// >>> tb/tb_top.sv
// tb_top: self-checking bench of the serial port controller
`timescale 1ns/1ps
module tb_top import spe_pkg::*; ;
   logic mclk = 1'h0, rst_n = 1'h0, en = 1'h0, dis = 1'h0, srst = 1'h0;
   logic mst = 1'h1, fixm = 1'h0, dma = 1'h0, cwr = 1'h0, txv = 1'h0, rxr = 1'h0;
   logic [CS_W-1:0] fcs = '0;
   logic [CS_N*DIV_W-1:0] div = '0;
   logic [CS_N*BITS_W-1:0] bits = '0;
   logic [CS_N-1:0] pol = '0, pha = '0, hold = '0, cs_n;
   logic [TXW-1:0] txd = '0;
   logic txr, rxv, ena, tempty, dhw, sclk, mosi, miso, lclk, lcs_n, lmosi;
   logic psclk = 1'h0, stall = 1'h0;
   logic [DW-1:0] rxd;
   logic [7:0] b;
   logic [16:0] note;
   logic [16:0] exp_q[$];
   int n_errors = 0, compares = 0, seed = 29, edges = 0, k;
   spe_core DUT (.mclk_i(mclk), .rst_n_i(rst_n), .enable_cmd_i(en), .disable_cmd_i(dis),
      .soft_reset_cmd_i(srst), .master_select_bit_i(mst), .fixed_mode_i(fixm),
      .dma_mode_i(dma), .fixed_cs_i(fcs), .baud_divisor_i(div), .bits_code_i(bits),
      .cpol_i(pol), .cpha_i(pha), .hold_select_after_transfer_i(hold), .config_wr_i(cwr),
      .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr), .rx_valid_o(rxv),
      .rx_data_o(rxd), .rx_ready_i(rxr), .enabled_o(ena), .transmit_empty_flag_o(tempty),
      .dma_halfword_o(dhw), .serial_clock_pin_o(sclk), .serial_clock_pin_oe_o(),
      .mosi_o(mosi), .mosi_oe_o(), .cs_n_o(cs_n), .miso_i(miso), .slv_clk_i(lclk),
      .slv_cs_n_i(lcs_n), .slv_mosi_i(lmosi), .slv_miso_o(), .slv_miso_oe_o());
   spe_peer P (.sclk_i(sclk), .cs_n_i(cs_n[0]), .mosi_i(mosi), .miso_o(miso),
      .lclk_o(lclk), .lcs_n_o(lcs_n), .lmosi_o(lmosi));
   always #25 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out;
      if (n_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic over;
      n_errors++;
      close_out;
   endtask : over
   task automatic tick;
      @(posedge mclk);
      #2;
   endtask : tick
   task automatic cmd(input logic [2:0] c);
      {en, dis, srst} = c;
      tick;
      {en, dis, srst} = 3'h0;
      tick;
   endtask : cmd
   // master is already selected when the selects are configured, except in the early-configuration check
   task automatic cfg(input logic [7:0] d, input logic [3:0] c, input logic p, input logic h);
      div = {CS_N{d}};
      bits = {CS_N{c}};
      pol = {CS_N{p}};
      pha = {CS_N{h}};
      cwr = 1'h1;
      tick;
      cwr = 1'h0;
      repeat (4) tick;
   endtask : cfg
   function automatic int exp_edges(input int d, input int n, input logic p, input logic h);
      return 2 * n + (((d % 2 == 1 && d != 1 && p && !h) || (d == 1 && n % 2 == 1)) ? 2 : 0);
   endfunction : exp_edges
   // hand one word over, then check clock edges and what the slave captured
   task automatic xfer(input logic [31:0] w, input int ne, input logic cc);
      exp_q.push_back({1'h0, 16'h0000});
      txd = w;
      txv = 1'h1;
      for (k = 0; k < 500 && txr !== 1'h1; k++) tick;
      if (k == 500) over;
      tick;
      txv = 1'h0;
      edges = 0;
      if (ne >= 0) begin
         for (k = 0; k < 900 && tempty !== 1'h1; k++) tick;
         if (k == 900) over;
         chk(edges, ne);
         if (cc) chk(P.cap[7:0], w[7:0]);
      end
   endtask : xfer
   task automatic drain;
      for (k = 0; k < 900 && exp_q.size() != 0; k++) tick;
      if (k == 900) over;
   endtask : drain
   ////////////////////////////////////////////////////////////////////////
   // count every level change of the serial clock pin
   always @(posedge mclk) begin
      if (sclk !== psclk) edges++;
      psclk = sclk;
   end
   // receiver stalls at random, or on purpose to fill the buffer
   always @(posedge mclk) begin
      #2;
      rxr = stall ? 1'h0 : 1'($random(seed));
   end
   // results are matched in order against the notes of the drivers
   always @(posedge mclk) begin
      if (rxv === 1'h1 && rxr === 1'h1) begin
         if (exp_q.size() == 0) chk(32'h0001, 32'h0000);
         else begin
            note = exp_q.pop_front();
            if (note[16]) chk(rxd, note[15:0]);
         end
      end
   end
   initial begin
      repeat (8) tick;
      chk({txr, rxv, cs_n, tempty}, 7'h1f);
      rst_n = 1'h1;
      cmd(3'h1);
      cmd(3'h1);
      cmd(3'h4);
      chk({ena, txr}, 2'h3);
      for (int c = 0; c < 9; c++) begin
         cfg(8'h01, 4'(c), 1'h0, 1'h0);
         xfer(32'($random(seed)) & 32'h0000_00ff, exp_edges(1, 8 + c, 0, 0), c == 0);
      end
      for (int d = 2; d < 6; d++) begin
         cfg(8'(d), 4'h0, 1'h1, 1'(d == 5));
         xfer(32'h0000_00a5, exp_edges(d, 8, 1, d == 5), 1'h0);
      end
      // divisor 2 keeps the held select clear of the resend hazard
      hold = 4'h1;
      fixm = 1'h1;
      dma = 1'h1;
      cfg(8'h02, 4'h0, 1'h0, 1'h0);
      xfer(32'h0000_003c, 16, 1'h1);
      chk(cs_n[0], 1'h0);
      xfer(32'h0100_00c3, 16, 1'h1);
      chk(cs_n[0], 1'h1);
      bits = 16'h0002;
      fcs = 2'h1;
      tick;
      chk(dhw, 1'h1);
      bits = 16'h0000;
      tick;
      chk(dhw, 1'h0);
      {hold, fixm, dma, fcs} = '0;
      drain;
      stall = 1'h1;
      xfer(32'h0000_0011, 16, 1'h0);
      xfer(32'h0000_0022, 16, 1'h0);
      xfer(32'h0000_0033, -1, 1'h0);
      repeat (60) tick;
      chk({tempty, cs_n[0]}, 2'h0);
      stall = 1'h0;
      drain;
      // divisor 1 with the select held sends the second word twice
      hold = 4'h1;
      cfg(8'h01, 4'h0, 1'h0, 1'h0);
      xfer(32'h0000_0012, 16, 1'h0);
      exp_q.push_back({1'h0, 16'h0000});
      xfer(32'h0100_0034, 32, 1'h0);
      hold = '0;
      // a lone soft reset lets the clock lead the select by one pulse
      cmd(3'h1);
      cmd(3'h4);
      xfer(32'h0000_005a, 18, 1'h0);
      cmd(3'h1);
      cmd(3'h4);
      // a disable mid-transfer keeps the sequencer sending dummy words
      drain;
      stall = 1'h1;
      xfer(32'h0000_0077, -1, 1'h0);
      repeat (4) tick;
      cmd(3'h2);
      repeat (150) tick;
      chk({ena, tempty}, 2'h0);
      chk(edges, 48);
      exp_q.push_back({1'h0, 16'h0000});
      cmd(3'h1);
      cmd(3'h1);
      cmd(3'h4);
      stall = 1'h0;
      drain;
      cmd(3'h2);
      chk(ena, 1'h0);
      mst = 1'h0;
      // configuration written while not master idles the clock inverted
      cfg(8'h02, 4'h0, 1'h0, 1'h0);
      chk(sclk, 1'h1);
      cmd(3'h4);
      for (int i = 0; i < 3; i++) begin
         b = 8'($random(seed));
         exp_q.push_back({1'h1, 8'h00, b});
         P.frame(b);
         repeat (4) tick;
      end
      cmd(3'h2);
      chk(ena, 1'h1);
      drain;
      cmd(3'h1);
      cmd(3'h1);
      chk(ena, 1'h0);
      close_out;
   end
endmodule : tb_top
